// >>> hw/dcrc_defines.svh
/*
  Register indices, reset values, bus answer codes and interrupt
  bit positions of the core run control block.
  Assumes a 4-byte bus word per register: byte address = 4 * index.
*/
`ifndef DCRC_DEFINES_SVH
`define DCRC_DEFINES_SVH

`define DCRC_IDX_W 18
`define DCRC_IDX_HIB 18'h0F400
`define DCRC_IDX_LAUNCH 18'h0F402
`define DCRC_IDX_HALT 18'h0F403
`define DCRC_IDX_ENTRY 18'h0F404
`define DCRC_IDX_STATE 18'h0F405
`define DCRC_IDX_CLEAR 18'h0F421
`define DCRC_IDX_PMASK 18'h0F422
`define DCRC_IDX_FLAG 18'h0F427
`define DCRC_IDX_ISTAT 18'h0F440
`define DCRC_IDX_IMASK 18'h0F441
`define DCRC_IDX_ESRC 18'h0F442

`define DCRC_PMASK_RST 16'h0003
`define DCRC_ENTRY_RST 16'h0000
`define DCRC_IRQ_RST 3'h0
`define DCRC_CTRL_BIT 0

`define DCRC_RESP_OKAY 2'h0
`define DCRC_RESP_SLVERR 2'h2

`define DCRC_IRQ_W 3
`define DCRC_IRQ_HALT 0
`define DCRC_IRQ_ERR 1
`define DCRC_IRQ_START 2

`endif

// >>> hw/dcrc_edge_det.sv
/*
  One edge-triggered control bit: stores the written value and flags
  a zero-to-one change in the cycle of the write.
  Assumes write strobe and data on the same clock as clk_i.
*/
`timescale 1ns/1ps
module dcrc_edge_det (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic bit_i,
  output logic level_o,
  output logic rise_o
);

  typedef struct packed {
    logic level;
  } dcrc_edge_state_t;

  dcrc_edge_state_t s;
  dcrc_edge_state_t next_s;

  // R18: new value against stored one
  // R2: falling change gives no pulse
  assign rise_o = wr_i & bit_i & ~s.level;
  assign level_o = s.level;

  always_comb begin
    next_s = s;
    if (wr_i) begin
      next_s.level = bit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  a_rise_stores: assert property (@(posedge clk_i) disable iff (srst_i)
    rise_o |=> level_o) else $error("rise not stored"); // R18
  a_fall_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_i && !bit_i) |-> !rise_o) else $error("pulse on fall"); // R2

endmodule : dcrc_edge_det

// >>> hw/dcrc_pkg.sv
/*
  Types shared by the core run control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dcrc_pkg;

  typedef enum logic [2:0] {
    st_off   = 3'b000,
    st_run   = 3'b001,
    st_pause = 3'b010,
    st_sleep = 3'b011,
    st_stall = 3'b100
  } dcrc_core_st_t;

endpackage : dcrc_pkg

// >>> hw/dcrc_top.sv
/*
  Core run control register bank: halt, launch, entry address, core
  state code, hibernate, error manager clear and parity report mask,
  with an interrupt status/mask pair, behind an AXI4-Lite slave.
  Assumes core-side inputs come from logic on clk_i (no synchroniser)
  and a master that keeps valid and payload steady until taken.
*/
// Added by the designer: the AXI4-Lite register port.
// What this block does
// R1: halt request rise stops core at once
// R2: halt bit falling change does nothing
// R3: software uses halt only when debugging
// R4: launch loads program counter from entry address
// R5: state code 000 at boot, after halt
// R6: state code 001 while running normally
// R7: pause gates core clock, code 010
// R8: sleep waits for sample, code 011
// R9: competing requests stall briefly, code 100
// R10: state field read-only, live at read
// R11: clear rise resets error flag, manager
// R12: software writes one then zero to clear
// R13: parity mask resets with two low bits set
// R14: launch rise starts core, fall ignored
// R15: hibernate masks interrupts, sleeps after frame
// R16: unmasked error sets master error flag
// R17: mask bit one suppresses that memory
// R18: edges found against previously stored bit
// R19: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "dcrc_defines.svh"
module dcrc_top #(
  parameter int ADDR_W = 20,
  parameter int PAR_W = 12
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic core_pause_i,
  input wire logic core_sleep_i,
  input wire logic core_stall_i,
  input wire logic core_frame_done_i,
  input wire logic [PAR_W-1:0] err_parity_i,
  output logic core_start_o,
  output logic [15:0] core_pc_o,
  output logic core_halt_o,
  output logic core_clk_en_o,
  output logic core_irq_en_o,
  output logic [2:0] core_state_o,
  output logic panic_flag_o,
  output logic irq_o
);

  localparam int IW = ADDR_W - 2;

  initial begin
    if (ADDR_W < `DCRC_IDX_W + 2 || ADDR_W > 32) begin
      $error("ADDR_W must be 20 to 32");
    end
    if (PAR_W < 2 || PAR_W > 16) begin
      $error("PAR_W must be 2 to 16");
    end
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    dcrc_pkg::dcrc_core_st_t core_st;
    logic hib;
    logic hib_sleep;
    logic [15:0] entry;
    logic [15:0] pc;
    logic start_p;
    logic halt_p;
    logic [PAR_W-1:0] pmask;
    logic flag;
    logic [PAR_W-1:0] src;
    logic [`DCRC_IRQ_W-1:0] ist;
    logic [`DCRC_IRQ_W-1:0] imask;
  } dcrc_top_state_t;

  dcrc_top_state_t s;
  dcrc_top_state_t next_s;

  logic wr_go;
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic wr_lane0;
  logic halt_rise, halt_lvl;
  logic launch_rise, launch_lvl;
  logic clr_rise, clr_lvl;
  logic [PAR_W-1:0] err_hits;
  logic err_hit;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  assign s_axil_awready_o = ~s.aw_held & ~s.bvalid;
  assign s_axil_wready_o = ~s.w_held & ~s.bvalid;
  assign s_axil_arready_o = ~s.rvalid;
  assign s_axil_bvalid_o = s.bvalid;
  assign s_axil_bresp_o = s.bresp;
  assign s_axil_rvalid_o = s.rvalid;
  assign s_axil_rdata_o = s.rdata;
  assign s_axil_rresp_o = s.rresp;

  assign wr_go = s.aw_held & s.w_held & ~s.bvalid;
  assign wr_idx = s.aw_addr[ADDR_W-1:2];
  assign rd_idx = s_axil_araddr_i[ADDR_W-1:2];
  assign wr_lane0 = wr_go & s.w_strb[0];

  dcrc_edge_det u_halt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_i(wr_lane0 && wr_idx == IW'(`DCRC_IDX_HALT)),
    .bit_i(s.w_data[`DCRC_CTRL_BIT]),
    .level_o(halt_lvl),
    .rise_o(halt_rise)
  );

  dcrc_edge_det u_launch (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_i(wr_lane0 && wr_idx == IW'(`DCRC_IDX_LAUNCH)),
    .bit_i(s.w_data[`DCRC_CTRL_BIT]),
    .level_o(launch_lvl),
    .rise_o(launch_rise)
  );

  dcrc_edge_det u_clear (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_i(wr_lane0 && wr_idx == IW'(`DCRC_IDX_CLEAR)),
    .bit_i(s.w_data[`DCRC_CTRL_BIT]),
    .level_o(clr_lvl),
    .rise_o(clr_rise)
  );

  // R16: unmasked errors feed the flag
  // R17: mask bit one silences a memory
  assign err_hits = err_parity_i & ~s.pmask;
  assign err_hit = |err_hits;

  always_comb begin
    wr_ok = 1'b1;
    unique case (wr_idx)
      IW'(`DCRC_IDX_HIB), IW'(`DCRC_IDX_LAUNCH), IW'(`DCRC_IDX_HALT),
      IW'(`DCRC_IDX_ENTRY), IW'(`DCRC_IDX_STATE), IW'(`DCRC_IDX_CLEAR),
      IW'(`DCRC_IDX_PMASK), IW'(`DCRC_IDX_FLAG), IW'(`DCRC_IDX_ISTAT),
      IW'(`DCRC_IDX_IMASK), IW'(`DCRC_IDX_ESRC): wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // R19: reserved bits come back as zero
  // R10: state code sampled at the read
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (rd_idx)
      IW'(`DCRC_IDX_HIB): rd_val = 32'(s.hib);
      IW'(`DCRC_IDX_LAUNCH): rd_val = 32'(launch_lvl);
      IW'(`DCRC_IDX_HALT): rd_val = 32'(halt_lvl);
      IW'(`DCRC_IDX_ENTRY): rd_val = 32'(s.entry);
      IW'(`DCRC_IDX_STATE): rd_val = 32'(s.core_st);
      IW'(`DCRC_IDX_CLEAR): rd_val = 32'(clr_lvl);
      IW'(`DCRC_IDX_PMASK): rd_val = 32'(s.pmask);
      IW'(`DCRC_IDX_FLAG): rd_val = 32'(s.flag);
      IW'(`DCRC_IDX_ISTAT): rd_val = 32'(s.ist);
      IW'(`DCRC_IDX_IMASK): rd_val = 32'(s.imask);
      IW'(`DCRC_IDX_ESRC): rd_val = 32'(s.src);
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    logic [15:0] pm16;
    logic [`DCRC_IRQ_W-1:0] w1c;
    logic [`DCRC_IRQ_W-1:0] ev;
    pm16 = 16'(s.pmask);
    w1c = '0;
    ev = '0;
    next_s = s;
    next_s.start_p = 1'b0;
    next_s.halt_p = 1'b0;
    if (s_axil_awvalid_i && s_axil_awready_o) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axil_awaddr_i;
    end
    if (s_axil_wvalid_i && s_axil_wready_o) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axil_wdata_i;
      next_s.w_strb = s_axil_wstrb_i;
    end
    if (s.bvalid && s_axil_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? `DCRC_RESP_OKAY : `DCRC_RESP_SLVERR;
      if (s.w_strb[0]) begin
        unique case (wr_idx)
          IW'(`DCRC_IDX_HIB): next_s.hib = s.w_data[`DCRC_CTRL_BIT];
          IW'(`DCRC_IDX_ENTRY): next_s.entry[7:0] = s.w_data[7:0];
          IW'(`DCRC_IDX_PMASK): pm16[7:0] = s.w_data[7:0];
          IW'(`DCRC_IDX_ISTAT): w1c = s.w_data[`DCRC_IRQ_W-1:0];
          IW'(`DCRC_IDX_IMASK): next_s.imask = s.w_data[`DCRC_IRQ_W-1:0];
          default: ;
        endcase
      end
      if (s.w_strb[1]) begin
        unique case (wr_idx)
          IW'(`DCRC_IDX_ENTRY): next_s.entry[15:8] = s.w_data[15:8];
          IW'(`DCRC_IDX_PMASK): pm16[15:8] = s.w_data[15:8];
          default: ;
        endcase
      end
      next_s.pmask = pm16[PAR_W-1:0];
    end
    if (s.rvalid && s_axil_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axil_arvalid_i && s_axil_arready_o) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val;
      next_s.rresp = rd_ok ? `DCRC_RESP_OKAY : `DCRC_RESP_SLVERR;
    end
    // R11: clear rise empties the manager
    // R16: a new error wins over the clear
    next_s.flag = (s.flag & ~clr_rise) | err_hit;
    next_s.src = (clr_rise ? '0 : s.src) | err_hits;
    // R1: halt rise overrides any state
    if (halt_rise) begin
      next_s.core_st = dcrc_pkg::st_off;
      next_s.hib_sleep = 1'b0;
      next_s.halt_p = 1'b1;
    // R4: launch reloads the program counter
    // R14: only the rising change launches
    end else if (launch_rise) begin
      next_s.core_st = dcrc_pkg::st_run;
      next_s.hib_sleep = 1'b0;
      next_s.start_p = 1'b1;
      next_s.pc = s.entry;
    end else begin
      unique case (s.core_st)
        dcrc_pkg::st_off: ;
        // R6: normal running reports code 001
        dcrc_pkg::st_run: begin
          // R9: stall has first claim
          // R15: hibernate waits for frame end
          if (core_stall_i) begin
            next_s.core_st = dcrc_pkg::st_stall;
          end else if (s.hib && core_frame_done_i) begin
            next_s.core_st = dcrc_pkg::st_sleep;
            next_s.hib_sleep = 1'b1;
          end else if (core_pause_i) begin
            next_s.core_st = dcrc_pkg::st_pause;
          end else if (core_sleep_i) begin
            next_s.core_st = dcrc_pkg::st_sleep;
          end
        end
        // R7: state kept until clock resumes
        dcrc_pkg::st_pause: begin
          if (!core_pause_i) begin
            next_s.core_st = dcrc_pkg::st_run;
          end
        end
        // R8: idle until next sample
        dcrc_pkg::st_sleep: begin
          if (!core_sleep_i && !(s.hib_sleep && s.hib)) begin
            next_s.core_st = dcrc_pkg::st_run;
            next_s.hib_sleep = 1'b0;
          end
        end
        // R9: resume at once when serviced
        dcrc_pkg::st_stall: begin
          if (!core_stall_i) begin
            next_s.core_st = dcrc_pkg::st_run;
          end
        end
        default: next_s.core_st = dcrc_pkg::st_off;
      endcase
    end
    ev[`DCRC_IRQ_HALT] = halt_rise;
    ev[`DCRC_IRQ_ERR] = err_hit;
    ev[`DCRC_IRQ_START] = launch_rise & ~halt_rise;
    // set beats a same-cycle clear
    next_s.ist = (s.ist & ~w1c) | ev;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.bresp <= `DCRC_RESP_OKAY;
      s.rresp <= `DCRC_RESP_OKAY;
      // R5: boot state is not running
      s.core_st <= dcrc_pkg::st_off;
      s.entry <= `DCRC_ENTRY_RST;
      // R13: two low mask bits set
      s.pmask <= PAR_W'(`DCRC_PMASK_RST);
      s.ist <= `DCRC_IRQ_RST;
      s.imask <= `DCRC_IRQ_RST;
    end else begin
      s <= next_s;
    end
  end

  assign core_start_o = s.start_p;
  assign core_pc_o = s.pc;
  assign core_halt_o = s.halt_p;
  assign core_state_o = s.core_st;
  // R7: paused or stopped core gets no clock
  assign core_clk_en_o = (s.core_st != dcrc_pkg::st_pause) &&
                         (s.core_st != dcrc_pkg::st_off);
  // R15: hibernate blocks interrupts
  assign core_irq_en_o = ~s.hib;
  assign irq_o = (|(s.ist & s.imask)) & ~s.hib;
  assign panic_flag_o = s.flag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_halt_stops: assert property (halt_rise |=> core_state_o == 3'b000
    && core_halt_o) else $error("halt did not stop core"); // R1
  a_halt_fall: assert property ($fell(halt_lvl) |=> !core_halt_o)
    else $error("halt fall acted"); // R2
  a_launch_pc: assert property ((launch_rise && !halt_rise) |=>
    core_start_o && core_pc_o == $past(s.entry) && core_state_o == 3'b001)
    else $error("launch wrong"); // R4
  a_boot_off: assert property ($fell(srst_i) |-> core_state_o == 3'b000
    && s.pmask == PAR_W'(`DCRC_PMASK_RST)) else $error("bad reset"); // R5
  a_pause_gate: assert property ((core_state_o == 3'b010) |->
    !core_clk_en_o) else $error("paused core clocked"); // R7
  a_sleep_code: assert property ((core_state_o == 3'b001 && core_sleep_i
    && !core_stall_i && !core_pause_i && !s.hib && !halt_rise
    && !launch_rise) |=> core_state_o == 3'b011)
    else $error("sleep not reported"); // R8
  a_stall_back: assert property ((core_state_o == 3'b100 && !core_stall_i
    && !halt_rise && !launch_rise) |=> core_state_o == 3'b001)
    else $error("stall did not resume"); // R9
  a_read_live: assert property ((s_axil_arvalid_i && s_axil_arready_o
    && rd_idx == IW'(`DCRC_IDX_STATE)) |=> s_axil_rvalid_o
    && s_axil_rdata_o == 32'($past(core_state_o)))
    else $error("state read stale"); // R10
  a_clear_flag: assert property ((clr_rise && !err_hit) |=> !panic_flag_o
    && s.src == '0) else $error("clear failed"); // R11
  a_err_sets: assert property (err_hit |=> panic_flag_o ##1 panic_flag_o
    || $past(clr_rise)) else $error("error not logged"); // R16
  a_mask_quiet: assert property ((!panic_flag_o && !err_hit && !clr_rise)
    |=> !panic_flag_o) else $error("masked error logged"); // R17
  a_hib_noirq: assert property (s.hib |-> !irq_o && !core_irq_en_o)
    else $error("irq during hibernate"); // R15
  a_resv_zero: assert property ((s_axil_arvalid_i && s_axil_arready_o)
    |=> s_axil_rdata_o[31:16] == 16'h0000)
    else $error("reserved bits nonzero"); // R19

  c_halt_run: cover property (core_state_o == 3'b001 ##1 halt_rise);
  c_pause: cover property (core_state_o == 3'b010 ##1 core_state_o == 3'b001);
  c_err_clear: cover property (panic_flag_o ##[1:20] clr_rise);
  c_hib_sleep: cover property (s.hib_sleep && core_state_o == 3'b011);

endmodule : dcrc_top

// >>> sim/dcrc_top_tb.sv
/*
  Self-checking bench of the core run control bank: AXI4-Lite
  traffic, core status inputs, parity errors and the interrupt.
  Assumes dcrc_top with default parameters and a 40 MHz clock.
*/
`timescale 1ns/1ps
`include "dcrc_defines.svh"
module dcrc_top_tb;
  localparam int AW = 20;
  localparam int PW = 12;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [AW-1:0] awa = '0;
  logic [AW-1:0] ara = '0;
  logic [31:0] wd = '0;
  logic [3:0] ws = '0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic pau = 1'b0, slp = 1'b0, stl = 1'b0, fd = 1'b0;
  logic [PW-1:0] err = '0;
  logic awr, wrdy, bv, arr, rv, go, hlt, cen, ien, flg, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rd;
  logic [15:0] pc;
  logic [2:0] cst;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_go = 0;
  int n_hlt = 0;

  dcrc_top dut (.clk_i(clk_i), .srst_i(srst_i),
    .s_axil_awaddr_i(awa), .s_axil_awvalid_i(awv),
    .s_axil_awready_o(awr), .s_axil_wdata_i(wd), .s_axil_wstrb_i(ws),
    .s_axil_wvalid_i(wv), .s_axil_wready_o(wrdy),
    .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bv),
    .s_axil_bready_i(br), .s_axil_araddr_i(ara),
    .s_axil_arvalid_i(arv), .s_axil_arready_o(arr),
    .s_axil_rdata_o(rd), .s_axil_rresp_o(rresp),
    .s_axil_rvalid_o(rv), .s_axil_rready_i(rr),
    .core_pause_i(pau), .core_sleep_i(slp), .core_stall_i(stl),
    .core_frame_done_i(fd), .err_parity_i(err), .core_start_o(go),
    .core_pc_o(pc), .core_halt_o(hlt), .core_clk_en_o(cen),
    .core_irq_en_o(ien), .core_state_o(cst), .panic_flag_o(flg),
    .irq_o(irq));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // pulses counted mid-cycle, clear of the edge updates
  always @(negedge clk_i) begin
    if (go === 1'b1) n_go++;
    if (hlt === 1'b1) n_hlt++;
  end

  function automatic logic [31:0] exp_st(input logic [2:0] k);
    if (k[2]) return 32'h00000004;
    if (k[0]) return 32'h00000002;
    if (k[1]) return 32'h00000003;
    return 32'h00000001;
  endfunction : exp_st

  function automatic logic [31:0] exp_flag(input logic [31:0] e,
                                           input logic [31:0] m);
    return 32'(|(e[PW-1:0] & ~m[PW-1:0]));
  endfunction : exp_flag

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic late(input int t);
    if (t >= 40) begin
      n_mismatch++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
  endtask : late

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // entered and left just after a rising edge
  task automatic bw(input logic [17:0] i, input logic [31:0] d,
                    input logic [3:0] s = 4'hF,
                    input logic [1:0] er = `DCRC_RESP_OKAY);
    logic a, w, pa, pw;
    logic [1:0] r;
    int t;
    a = 1'b0;
    w = 1'b0;
    t = 0;
    awa <= {i, 2'b00};
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(a && w) && t < 40) begin
      @(negedge clk_i);
      pa = !a && awr === 1'b1;
      pw = !w && wrdy === 1'b1;
      @(posedge clk_i);
      if (pa) awv <= 1'b0;
      if (pw) wv <= 1'b0;
      a = a || pa;
      w = w || pw;
      t++;
    end
    pa = 1'b0;
    while (!pa && t < 40) begin
      @(negedge clk_i);
      pa = bv === 1'b1;
      r = bresp;
      @(posedge clk_i);
      t++;
    end
    br <= 1'b0;
    // an edge between transfers keeps bready from two writes in one step
    @(posedge clk_i);
    late(t);
    chk(32'(r), 32'(er));
  endtask : bw

  task automatic brd(input logic [17:0] i, output logic [31:0] d,
                     output logic [1:0] r);
    logic a, g;
    int t;
    g = 1'b0;
    t = 0;
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    while (!g && t < 40) begin
      @(negedge clk_i);
      a = arr === 1'b1;
      g = rv === 1'b1;
      d = rd;
      r = rresp;
      @(posedge clk_i);
      if (a) arv <= 1'b0;
      t++;
    end
    rr <= 1'b0;
    @(posedge clk_i);
    late(t);
  endtask : brd

  task automatic rchk(input logic [17:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    brd(i, d, r);
    chk(d, e);
    chk(32'(r), 32'(`DCRC_RESP_OKAY));
  endtask : rchk

  initial begin
    logic [31:0] d, e, m;
    logic [1:0] r;
    int k;
    void'($urandom(32'hC4D427D1));
    cyc(4);
    srst_i <= 1'b0;
    rchk(`DCRC_IDX_HALT, 32'h00000000);
    rchk(`DCRC_IDX_ENTRY, 32'h00000000);
    rchk(`DCRC_IDX_STATE, 32'h00000000);
    rchk(`DCRC_IDX_CLEAR, 32'h00000000);
    rchk(`DCRC_IDX_PMASK, 32'h00000003);
    chk(32'(irq), 32'h00000000);
    bw(18'h0F406, 32'h0000FFFF, 4'hF, `DCRC_RESP_SLVERR);
    brd(18'h0F406, d, r);
    chk(d, 32'h00000000);
    chk(32'(r), 32'(`DCRC_RESP_SLVERR));
    bw(`DCRC_IDX_STATE, 32'h0000FFFF);
    rchk(`DCRC_IDX_STATE, 32'h00000000);
    e = $urandom & 32'h0000FFFF;
    bw(`DCRC_IDX_ENTRY, e | 32'hA5A50000);
    rchk(`DCRC_IDX_ENTRY, e);
    d = $urandom;
    bw(`DCRC_IDX_ENTRY, d, 4'h2);
    e = {16'h0000, d[15:8], e[7:0]};
    rchk(`DCRC_IDX_ENTRY, e);
    k = n_go;
    bw(`DCRC_IDX_LAUNCH, 32'h00000001);
    bw(`DCRC_IDX_LAUNCH, 32'h00000001);
    bw(`DCRC_IDX_LAUNCH, 32'h00000000);
    cyc(2);
    chk(32'(n_go - k), 32'h00000001);
    chk(32'(pc), e);
    chk(32'(cst), 32'h00000001);
    for (k = 0; k < 8; k++) begin
      // every state returns to run once the core inputs drop
      pau <= 1'b0;
      slp <= 1'b0;
      stl <= 1'b0;
      cyc(1);
      pau <= k[0];
      slp <= k[1];
      stl <= k[2];
      cyc(2);
      rchk(`DCRC_IDX_STATE, exp_st(k[2:0]));
      chk(32'(cen), 32'(exp_st(k[2:0]) != 32'h2));
    end
    pau <= 1'b1;
    stl <= 1'b0;
    slp <= 1'b0;
    cyc(2);
    k = n_hlt;
    bw(`DCRC_IDX_HALT, 32'hFFFFFFFF);
    pau <= 1'b0;
    cyc(2);
    chk(32'(n_hlt - k), 32'h00000001);
    rchk(`DCRC_IDX_STATE, 32'h00000000);
    rchk(`DCRC_IDX_HALT, 32'h00000001);
    bw(`DCRC_IDX_LAUNCH, 32'h00000001);
    k = n_hlt;
    bw(`DCRC_IDX_HALT, 32'h00000001);
    bw(`DCRC_IDX_HALT, 32'h00000000);
    cyc(2);
    chk(32'(n_hlt - k), 32'h00000000);
    chk(32'(cst), 32'h00000001);
    fd <= 1'b1;
    cyc(1);
    fd <= 1'b0;
    cyc(2);
    chk(32'(cst), 32'h00000001);
    bw(`DCRC_IDX_HIB, 32'h00000001);
    chk(32'(ien), 32'h00000000);
    fd <= 1'b1;
    cyc(1);
    fd <= 1'b0;
    cyc(2);
    chk(32'(cst), 32'h00000003);
    bw(`DCRC_IDX_HIB, 32'h00000000);
    chk(32'(ien), 32'h00000001);
    for (k = 0; k < 8; k++) begin
      m = $urandom & 32'h00000FFF;
      e = $urandom & 32'h00000FFF;
      if (k == 0) m = 32'h00000003;
      if (k == 0) e = 32'h00000003;
      if (k == 1) m = 32'h00000000;
      bw(`DCRC_IDX_PMASK, m | 32'h0000F000);
      rchk(`DCRC_IDX_PMASK, m);
      bw(`DCRC_IDX_CLEAR, 32'h00000001);
      bw(`DCRC_IDX_CLEAR, 32'h00000000);
      chk(32'(flg), 32'h00000000);
      err <= e[PW-1:0];
      cyc(1);
      err <= '0;
      cyc(2);
      chk(32'(flg), exp_flag(e, m));
      rchk(`DCRC_IDX_FLAG, exp_flag(e, m));
    end
    // random mask left by the loop could hide the injected error
    bw(`DCRC_IDX_PMASK, 32'h00000003);
    bw(`DCRC_IDX_IMASK, 32'h00000000);
    bw(`DCRC_IDX_ISTAT, 32'h00000007);
    rchk(`DCRC_IDX_ISTAT, 32'h00000000);
    err <= 12'h004;
    cyc(1);
    err <= '0;
    cyc(2);
    chk(32'(irq), 32'h00000000);
    rchk(`DCRC_IDX_ISTAT, 32'(1 << `DCRC_IRQ_ERR));
    bw(`DCRC_IDX_IMASK, 32'(1 << `DCRC_IRQ_ERR));
    chk(32'(irq), 32'h00000001);
    bw(`DCRC_IDX_HIB, 32'h00000001);
    chk(32'(irq), 32'h00000000);
    bw(`DCRC_IDX_HIB, 32'h00000000);
    chk(32'(irq), 32'h00000001);
    bw(`DCRC_IDX_ISTAT, 32'(1 << `DCRC_IRQ_ERR));
    chk(32'(irq), 32'h00000000);
    // a fresh launch rise logs its event
    bw(`DCRC_IDX_LAUNCH, 32'h00000000);
    bw(`DCRC_IDX_LAUNCH, 32'h00000001);
    rchk(`DCRC_IDX_ISTAT, 32'(1 << `DCRC_IRQ_START));
    summarize();
  end

  // the sequence needs about 370 cycles; this allows plenty more
  initial begin
    cyc(20000);
    n_mismatch++;
    summarize();
  end
endmodule : dcrc_top_tb
